// ===== hdl/flash_pin_protect_reset_ctrl.sv
// Serial flash pin control: output timing, write-protect gating, reset pin.
// Assumes a host drives chip select, shift clock, serial in, write-protect, reset.
// Notes on behaviour
// RULE1 - Output bit changes only on shift clock fall
// RULE2 - Output tri-stated while chip select is high
// RULE3 - Write-protect low blocks guarded sectors always
// RULE4 - Guard map frozen while write-protect is low
// RULE5 - Program/erase under write-protect is discarded
// RULE6 - Discarded command returns idle on deselect
// RULE7 - Protect-enable and lock still run under write-protect
// RULE8 - Floating write-protect reads as deasserted
// RULE9 - Reset pin low aborts and idles
// RULE10 - No commands taken while reset held low
// RULE11 - Commands resume from idle after reset high
// RULE12 - Chip select frames operations; busy outlives deselect
// RULE13 - Serial input sampled on rise, ignored deselected
// RULE14 - Bytes shifted MSB first, opcode first
// RULE15 - Pins synchronised; write-protect checked at decode
module flash_pin_protect_reset_ctrl #(
  parameter int OP_CYCLES = fpr_pkg::OP_CYCLES_DEF
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CS_N_I,
  input  wire logic       SCK_I,
  input  wire logic       SI_I,
  input  wire logic       WP_N_I,
  input  wire logic       WP_DRIVEN_I,
  input  wire logic       RESET_N_I,
  output logic            SO_O,
  output logic            SO_OE_N_O,
  output logic            BUSY_O,
  output logic            OP_START_O,
  output logic            OP_REJECT_O,
  output logic [7:0]      GUARD_MAP_O
);
  typedef struct packed {
    fpr_pkg::state_t            st;
    logic [2:0]                 bitcnt;
    logic [7:0]                 sh;
    logic [7:0]                 op;
    logic [7:0]                 tx;
    logic [fpr_pkg::BUSY_W-1:0] busy_cnt;
    logic                       busy;
    logic [7:0]                 guard;
    logic [7:0]                 lock;
    logic                       prot_en;
    logic                       rejected;
    logic                       so;
    logic                       so_oe_n;
    logic                       start;
    logic                       reject;
  } ctrl_t;

  pin_if pins ();
  ctrl_t s_ff;
  ctrl_t nxt_s;
  logic  byte_done;
  logic  [7:0] rx_byte;

  localparam logic [fpr_pkg::BUSY_W-1:0] OP_LEN = OP_CYCLES[fpr_pkg::BUSY_W-1:0];

  pin_sampler u_samp (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .cs_n_i      (CS_N_I),
    .sck_i       (SCK_I),
    .si_i        (SI_I),
    .wp_n_i      (WP_N_I),
    .wp_driven_i (WP_DRIVEN_I),
    .reset_n_i   (RESET_N_I),
    .pins        (pins)
  );

  function automatic logic is_prog_erase(input logic [7:0] op);
    return (op == fpr_pkg::CMD_PROGRAM) || (op == fpr_pkg::CMD_ERASE);
  endfunction

  // Byte completes on the eighth rising edge, first bit in lands in the MSB
  assign rx_byte   = {s_ff.sh[6:0], pins.si}; // RULE14
  assign byte_done = pins.cs_act && pins.sck_rise && (s_ff.bitcnt == 3'h7);

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.start  = 1'b0;
    nxt_s.reject = 1'b0;
    if (s_ff.busy_cnt != '0) begin
      nxt_s.busy_cnt = s_ff.busy_cnt - 1'b1; // RULE12
    end
    if (pins.cs_act && pins.sck_rise && (s_ff.st != fpr_pkg::ST_IDLE)) begin
      nxt_s.sh     = rx_byte; // RULE13
      nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
    end
    case (s_ff.st)
      fpr_pkg::ST_IDLE: begin
      end
      fpr_pkg::ST_OPCODE: begin
        if (byte_done) begin
          nxt_s.op = rx_byte;
          if (is_prog_erase(rx_byte)) begin
            if (pins.wp_act || s_ff.busy_cnt != '0) begin
              nxt_s.st       = fpr_pkg::ST_IGNORE; // RULE5 RULE15
              nxt_s.rejected = 1'b1;
              nxt_s.reject   = 1'b1;
            end else begin
              nxt_s.st = fpr_pkg::ST_ARG;
            end
          end else if (rx_byte == fpr_pkg::CMD_STATUS) begin
            nxt_s.st = fpr_pkg::ST_SEND;
            nxt_s.tx = {s_ff.busy_cnt != '0, pins.wp_act, s_ff.prot_en, s_ff.rejected, 4'h0};
          end else if (rx_byte == fpr_pkg::CMD_PROT_EN) begin
            nxt_s.prot_en = 1'b1; // RULE7
            nxt_s.st      = fpr_pkg::ST_IGNORE;
          end else if (rx_byte == fpr_pkg::CMD_LOCK || rx_byte == fpr_pkg::CMD_GUARD_WR) begin
            nxt_s.st = fpr_pkg::ST_ARG;
          end else begin
            nxt_s.st = fpr_pkg::ST_IGNORE;
          end
        end
      end
      fpr_pkg::ST_ARG: begin
        if (byte_done) begin
          nxt_s.st = fpr_pkg::ST_IGNORE;
          if (is_prog_erase(s_ff.op)) begin
            // Hardware pin guards marked sectors even without software enable
            if (pins.wp_act || s_ff.lock[rx_byte[2:0]] ||
                ((s_ff.prot_en || pins.wp_act) && s_ff.guard[rx_byte[2:0]])) begin
              nxt_s.rejected = 1'b1; // RULE3 RULE5
              nxt_s.reject   = 1'b1;
            end else begin
              nxt_s.busy_cnt = OP_LEN;
              nxt_s.start    = 1'b1;
              nxt_s.rejected = 1'b0;
            end
          end else if (s_ff.op == fpr_pkg::CMD_LOCK) begin
            nxt_s.lock[rx_byte[2:0]] = 1'b1; // RULE7
          end else if (!pins.wp_act) begin
            nxt_s.guard = rx_byte; // RULE4
          end
        end
      end
      fpr_pkg::ST_SEND: begin
        if (pins.cs_act && pins.sck_fall) begin
          nxt_s.so = s_ff.tx[7]; // RULE1 RULE14
          nxt_s.tx = {s_ff.tx[6:0], s_ff.tx[7]};
        end
      end
      fpr_pkg::ST_IGNORE: begin
      end
      default: nxt_s.st = fpr_pkg::ST_IDLE;
    endcase
    if (pins.cs_fall) begin
      nxt_s.st     = fpr_pkg::ST_OPCODE; // RULE12 RULE14
      nxt_s.bitcnt = 3'h0;
    end
    if (pins.cs_rise) begin
      nxt_s.st = fpr_pkg::ST_IDLE; // RULE6
    end
    nxt_s.so_oe_n = !(pins.cs_act && nxt_s.st == fpr_pkg::ST_SEND); // RULE2
    // Reset pin overrides state, busy count, pulses and output enable; maps survive, operations do not
    if (pins.rst_act) begin
      nxt_s.st       = fpr_pkg::ST_IDLE; // RULE9 RULE10 RULE11
      nxt_s.busy_cnt = '0;
      nxt_s.start    = 1'b0;
      nxt_s.reject   = 1'b0;
      nxt_s.so_oe_n  = 1'b1;
    end
    // Own flop so the busy pin carries no compare logic
    nxt_s.busy = (nxt_s.busy_cnt != '0); // RULE12
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_ff <= '{st: fpr_pkg::ST_IDLE, bitcnt: 3'h0, sh: 8'h00, op: 8'h00, tx: 8'h00,
                busy_cnt: '0, busy: 1'b0, guard: fpr_pkg::MAP_RST_VAL, lock: fpr_pkg::MAP_RST_VAL,
                prot_en: 1'b0, rejected: 1'b0, so: 1'b0, so_oe_n: 1'b1, start: 1'b0, reject: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign SO_O        = s_ff.so;
  assign SO_OE_N_O   = s_ff.so_oe_n;
  assign BUSY_O      = s_ff.busy;
  assign OP_START_O  = s_ff.start;
  assign OP_REJECT_O = s_ff.reject;
  assign GUARD_MAP_O = s_ff.guard;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  so_edge_a: assert property ($changed(s_ff.so) |-> $past(pins.sck_fall)) // RULE1
    else $error("Serial output changed away from a falling shift edge");
  hiz_desel_a: assert property (!pins.cs_act |=> s_ff.so_oe_n) // RULE2
    else $error("Serial output driven while deselected");
  wp_start_a: assert property (s_ff.start |-> !$past(pins.wp_act)) // RULE3
    else $error("Operation started under write-protect");
  guard_frozen_a: assert property ($past(pins.wp_act) |-> $stable(s_ff.guard)) // RULE4
    else $error("Guard map changed under write-protect");
  wp_discard_a: assert property (s_ff.st == fpr_pkg::ST_OPCODE && byte_done && pins.wp_act &&
                                 is_prog_erase(rx_byte) && !pins.rst_act && !pins.cs_rise
                                 |=> s_ff.reject ##1 !s_ff.start[*2]) // RULE5
    else $error("Protected program or erase not discarded");
  ignore_idle_a: assert property (s_ff.st == fpr_pkg::ST_IGNORE && pins.cs_rise |=>
                                  s_ff.st == fpr_pkg::ST_IDLE) // RULE6
    else $error("Ignored command did not return to idle");
  prot_en_wp_a: assert property (s_ff.st == fpr_pkg::ST_OPCODE && byte_done && pins.wp_act &&
                                 rx_byte == fpr_pkg::CMD_PROT_EN && !pins.rst_act |=> s_ff.prot_en) // RULE7
    else $error("Protect enable refused under write-protect");
  rst_abort_a: assert property (pins.rst_act |=> s_ff.st == fpr_pkg::ST_IDLE && !BUSY_O && s_ff.so_oe_n) // RULE9
    else $error("Reset pin did not abort to idle");
  rst_hold_a: assert property (pins.rst_act[*2] |-> !s_ff.start && !s_ff.reject) // RULE10
    else $error("Command taken while reset held");
  busy_desel_a: assert property (s_ff.busy_cnt > 16'h0001 && !pins.rst_act |=> BUSY_O) // RULE12
    else $error("Busy ended early");
  msb_shift_a: assert property (pins.cs_act && pins.sck_rise && s_ff.st == fpr_pkg::ST_OPCODE
                                |=> s_ff.sh[0] == $past(pins.si)) // RULE13
    else $error("Serial input not shifted in at rising edge");

  start_c: cover property (s_ff.start);
  reject_c: cover property (s_ff.reject ##[1:400] pins.cs_rise);
  status_c: cover property (s_ff.st == fpr_pkg::ST_SEND && !s_ff.so_oe_n);
  rst_c: cover property (BUSY_O ##1 pins.rst_act);
endmodule

// ===== hdl/fpr_pkg.sv
// Constants shared by the serial flash pin, protect and reset control.
// Assumes a single 100 MHz core clock sampling all pins.
package fpr_pkg;
  localparam logic [7:0] CMD_PROGRAM  = 8'h02;
  localparam logic [7:0] CMD_ERASE    = 8'h20;
  localparam logic [7:0] CMD_STATUS   = 8'h05;
  localparam logic [7:0] CMD_PROT_EN  = 8'h3d;
  localparam logic [7:0] CMD_LOCK     = 8'h7f;
  localparam logic [7:0] CMD_GUARD_WR = 8'hfc;
  localparam int         OP_CYCLES_DEF = 64;
  localparam int         BUSY_W        = 16;
  localparam logic [4:0] PIN_RST_VAL   = 5'h19;
  localparam int         PIN_CS        = 0;
  localparam int         PIN_SCK       = 1;
  localparam int         PIN_SI        = 2;
  localparam int         PIN_WP        = 3;
  localparam int         PIN_RST       = 4;
  localparam logic [7:0] MAP_RST_VAL   = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ARG    = 3'b010,
    ST_SEND   = 3'b011,
    ST_IGNORE = 3'b100
  } state_t;
endpackage

// ===== hdl/pin_if.sv
// Sampled pin levels and edges passed from the pin sampler to the control.
// Assumes both ends run on the same core clock.
interface pin_if;
  logic cs_act;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si;
  logic wp_act;
  logic rst_act;
  modport src (output cs_act, cs_fall, cs_rise, sck_rise, sck_fall, si, wp_act, rst_act);
  modport dst (input  cs_act, cs_fall, cs_rise, sck_rise, sck_fall, si, wp_act, rst_act);
endinterface

// ===== hdl/pin_sampler.sv
// Two-stage synchronisers and edge finders for the serial flash pins.
// Assumes pins are asynchronous to CLK_I and the shift clock is much slower.
module pin_sampler (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  input  wire logic wp_driven_i,
  input  wire logic reset_n_i,
  pin_if.src        pins
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic       cs_q;
    logic       sck_q;
    logic       drv_s1;
    logic       drv_s2;
  } samp_t;

  samp_t r_ff;
  samp_t nxt_r;

  always_comb begin
    nxt_r        = r_ff;
    nxt_r.s1     = {reset_n_i, wp_n_i, si_i, sck_i, cs_n_i}; // RULE15
    nxt_r.s2     = r_ff.s1;
    nxt_r.drv_s1 = wp_driven_i; // RULE8
    nxt_r.drv_s2 = r_ff.drv_s1;
    nxt_r.cs_q  = r_ff.s2[fpr_pkg::PIN_CS];
    nxt_r.sck_q = r_ff.s2[fpr_pkg::PIN_SCK];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_ff <= '{s1: fpr_pkg::PIN_RST_VAL, s2: fpr_pkg::PIN_RST_VAL, cs_q: 1'b1, sck_q: 1'b0,
                drv_s1: 1'b1, drv_s2: 1'b1};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pins.cs_act   = !r_ff.s2[fpr_pkg::PIN_CS];
  assign pins.cs_fall  = r_ff.cs_q && !r_ff.s2[fpr_pkg::PIN_CS]; // RULE12
  assign pins.cs_rise  = !r_ff.cs_q && r_ff.s2[fpr_pkg::PIN_CS]; // RULE12
  assign pins.sck_rise = !r_ff.sck_q && r_ff.s2[fpr_pkg::PIN_SCK];
  assign pins.sck_fall = r_ff.sck_q && !r_ff.s2[fpr_pkg::PIN_SCK];
  assign pins.si       = r_ff.s2[fpr_pkg::PIN_SI];
  // Undriven pin reads high, as the internal pull-up would make it
  assign pins.wp_act   = r_ff.drv_s2 && !r_ff.s2[fpr_pkg::PIN_WP]; // RULE3 RULE8
  assign pins.rst_act  = !r_ff.s2[fpr_pkg::PIN_RST]; // RULE9

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pullup_idle_a: assert property ((!wp_driven_i)[*3] |=> !pins.wp_act) // RULE8
    else $error("Floating write-protect read as asserted");
endmodule

// ===== tb/host_model.sv
// Host side of the serial link: chip select, shift clock, serial in, reads serial out.
// Assumes the core clock paces it; shift clock is 160 ns and stands low between frames.
module host_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_n_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cs_n_o = 1'b1;
  initial sck_o = 1'b0;
  initial si_o = 1'b0;
  // Idle input toggles so the device cannot lean on a stale level
  always @(posedge clk_i) if (cs_n_o) si_o <= ~si_o;
  task automatic xfer_bit(input logic b, output logic s);
    @(posedge clk_i);
    sck_o <= 1'b0;
    si_o  <= b;
    repeat (8) @(posedge clk_i);
    // Released line has no pull: read it as the inverse of the stale bit
    s = so_oe_n_i ? ~so_i : so_i;
    sck_o <= 1'b1;
    repeat (7) @(posedge clk_i);
  endtask
  task automatic frame(input logic [7:0] op, input logic [7:0] arg, input int nb, output logic [7:0] rd);
    logic s;
    rd = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) xfer_bit(op[i], s);
    for (int i = 7; i >= 0; i--) if (nb > 1) begin
      xfer_bit(arg[i], s);
      rd[i] = s;
    end
    repeat (8) @(posedge clk_i);
    sck_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the flash pin, write-protect and reset control.
// Assumes host_model drives the link; the bench drives write-protect and reset pins.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPC = 200;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  logic        wp_drv = 1'b1;
  logic        reset_n = 1'b1;
  logic        cs_n, sck, si, so, so_oe_n, busy, start, rej;
  logic [7:0]  map, rd, g;
  logic [15:0] lfsr = 16'h8d0e;
  logic [1:0]  exp_q[$];
  int          n_fail = 0;
  int          num_checks = 0;
  int          busy_len = 0;
  always #5 clk = ~clk;
  flash_pin_protect_reset_ctrl #(.OP_CYCLES(OPC)) i_dut (
    .CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si), .WP_N_I(wp_n),
    .WP_DRIVEN_I(wp_drv), .RESET_N_I(reset_n), .SO_O(so), .SO_OE_N_O(so_oe_n), .BUSY_O(busy),
    .OP_START_O(start), .OP_REJECT_O(rej), .GUARD_MAP_O(map));
  host_model i_host (.clk_i(clk), .so_i(so), .so_oe_n_i(so_oe_n), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Expected pulse kind: 01 start, 10 reject
  task automatic cmd(input logic [7:0] o, input logic [7:0] a, input int nb, input logic [1:0] e);
    if (e != 2'b00) exp_q.push_back(e);
    i_host.frame(o, a, nb, rd);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < OPC + 8 && busy !== 1'b0; i++) @(posedge clk);
    cmp8(8'(busy), 8'h00);
  endtask
  // Any pulse without a note is a mismatch
  always @(negedge clk) if (start === 1'b1 || rej === 1'b1) begin
    cmp8({6'h00, rej, start}, exp_q.size() > 0 ? {6'h00, exp_q.pop_front()} : 8'h00);
  end
  // Operations cut short by the reset pin are left out of the length check
  always @(negedge clk) begin
    if (busy === 1'b1) begin
      busy_len++;
    end else if (busy_len != 0) begin
      if (reset_n === 1'b1) cmp8(8'(busy_len), 8'(OPC));
      busy_len = 0;
    end
  end
  initial begin
    #200us;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    lfsr = lfsr_next(lfsr);
    // Sector 0 guarded, sector 3 free, the rest random
    g = (lfsr[7:0] & 8'hf7) | 8'h01;
    cmd(fpr_pkg::CMD_GUARD_WR, g, 2, 2'b00);
    cmp8(map, g);
    cmd(fpr_pkg::CMD_PROGRAM, 8'h03, 2, 2'b01);
    cmp8(8'(busy), 8'h01);
    cmp8(8'(so_oe_n), 8'h01);
    wait_idle();
    cmd(fpr_pkg::CMD_STATUS, 8'h00, 2, 2'b00);
    cmp8(rd, 8'h00);
    @(posedge clk) wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(fpr_pkg::CMD_GUARD_WR, ~g, 2, 2'b00);
    cmp8(map, g);
    cmd(fpr_pkg::CMD_PROGRAM, 8'h03, 2, 2'b10);
    cmd(fpr_pkg::CMD_ERASE, 8'h00, 2, 2'b10);
    cmp8(8'(busy), 8'h00);
    cmd(fpr_pkg::CMD_PROT_EN, 8'h00, 1, 2'b00);
    cmd(fpr_pkg::CMD_LOCK, 8'h06, 2, 2'b00);
    cmd(fpr_pkg::CMD_STATUS, 8'h00, 2, 2'b00);
    cmp8(rd, 8'h70);
    @(posedge clk) wp_drv <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(fpr_pkg::CMD_PROGRAM, 8'h03, 2, 2'b01);
    cmd(fpr_pkg::CMD_ERASE, 8'h03, 2, 2'b10);
    wait_idle();
    cmd(fpr_pkg::CMD_PROGRAM, 8'h00, 2, 2'b10);
    cmd(fpr_pkg::CMD_ERASE, 8'h06, 2, 2'b10);
    cmd(fpr_pkg::CMD_ERASE, 8'h03, 2, 2'b01);
    @(posedge clk) reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    cmp8(8'(busy), 8'h00);
    cmp8(8'(so_oe_n), 8'h01);
    cmd(fpr_pkg::CMD_PROGRAM, 8'h03, 2, 2'b00);
    @(posedge clk) reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(fpr_pkg::CMD_PROGRAM, 8'h03, 2, 2'b01);
    wait_idle();
    cmp8(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule
